// *** fpm_pkg.sv ***
// constants and carrier types for the flash page map and protection block
// assumes a 16-bit cpu address bus and an 8-bit page select value
package fpm_pkg;

   // ----------------------------------------
   // cpu flash windows
   // ----------------------------------------
   localparam logic [15:0] FLASH_FIRST = 16'h4000;
   localparam logic [15:0] FIXED_LO_LAST = 16'h7FFF;
   localparam logic [15:0] MID_FIRST = 16'h8000;
   localparam logic [15:0] MID_LAST = 16'hBFFF;
   localparam logic [15:0] FIXED_HI_FIRST = 16'hC000;
   localparam logic [15:0] FLASH_LAST = 16'hFFFF;

   // ----------------------------------------
   // page select values
   // ----------------------------------------
   localparam logic [7:0] PAGE_FIRST = 8'h30;
   localparam logic [7:0] PAGE_LAST = 8'h3F;
   localparam logic [7:0] PAGE_FIXED_LO = 8'h3E;
   localparam logic [7:0] PAGE_FIXED_HI = 8'h3F;
   localparam logic [1:0] TOP_BLOCK = 2'h3;

   // ----------------------------------------
   // protection and options field in block 0
   // ----------------------------------------
   localparam logic [15:0] KEY_FIRST = 16'hFF00;
   localparam logic [15:0] KEY_LAST = 16'hFF07;
   localparam logic [15:0] PROT_BYTE_FIRST = 16'hFF0A;
   localparam logic [15:0] PROT_BYTE_LAST = 16'hFF0D;
   localparam logic [15:0] SEC_BYTE = 16'hFF0F;

   // ----------------------------------------
   // register window
   // ----------------------------------------
   localparam logic [15:0] REG_BASE = 16'h0000;
   localparam logic [15:0] REG_FIRST = 16'h0100;
   localparam logic [15:0] REG_LAST = 16'h010F;
   localparam logic [3:0] BANKED_FIRST = 4'h4;
   localparam logic [3:0] BANKED_LAST = 4'hB;

   // ----------------------------------------
   // protection byte fields
   // ----------------------------------------
   localparam int PROT_OPEN_BIT = 7;
   localparam int PROT_HI_DIS_BIT = 5;
   localparam int PROT_HI_SZ_LSB = 3;
   localparam int PROT_LO_DIS_BIT = 2;
   localparam int PROT_LO_SZ_LSB = 0;
   localparam logic OPEN_PROTECTING = 1'b0;
   localparam logic AREA_DISABLED = 1'b1;
   localparam logic [16:0] AREA_MIN_BYTES = 17'h00200;
   localparam logic [16:0] LOWER_AREA_BASE = 17'h08000;
   localparam logic [16:0] BLOCK_END = 17'h10000;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [1:0] RST_BLOCK = 2'h0;
   localparam logic [15:0] RST_ADDR = 16'h0000;
   localparam logic [3:0] RST_REG_OFFSET = 4'h0;

   typedef struct packed {
      logic hit;
      logic [1:0] block;
      logic [15:0] addr;
   } fpm_map_s;

   typedef struct packed {
      fpm_map_s rd;
      logic reg_hit;
      logic reg_banked;
      logic [3:0] reg_offset;
      logic [1:0] reg_bank;
      logic key_hit;
      logic prot_byte_hit;
      logic [1:0] prot_byte_block;
      logic sec_byte_hit;
      logic pe_grant;
      logic pe_violation;
   } fpm_state_s;

endpackage

// *** fpm_area_check.sv ***
// protection test for one block-relative address against one protection byte
// assumes the address is already mapped into its 64 KB block
`timescale 1ns/10ps
`default_nettype none
module fpm_area_check
(
   input wire logic [15:0] addr_i,
   input wire logic [7:0] prot_i,
   output logic protected_o
);
   import fpm_pkg::*;

   logic [16:0] lo_size;
   logic [16:0] hi_size;
   logic [16:0] a;
   logic in_lo;
   logic in_hi;
   logic whole;

   always_comb
   begin
      a = {1'b0, addr_i};
      // sizes step 512, 1K, 2K, 4K
      lo_size = AREA_MIN_BYTES << prot_i[PROT_LO_SZ_LSB +: 2]; // R14
      hi_size = AREA_MIN_BYTES << prot_i[PROT_HI_SZ_LSB +: 2]; // R14
      // lower grows up from page start, higher down from page end
      in_lo = (prot_i[PROT_LO_DIS_BIT] != AREA_DISABLED) && (a >= LOWER_AREA_BASE)
         && (a < LOWER_AREA_BASE + lo_size); // R08
      in_hi = (prot_i[PROT_HI_DIS_BIT] != AREA_DISABLED) && (a >= BLOCK_END - hi_size); // R08
      whole = prot_i[PROT_OPEN_BIT] == OPEN_PROTECTING; // R07
      protected_o = whole | in_lo | in_hi; // R16
   end
endmodule
`default_nettype wire

// *** fpm_page_map.sv ***
// flash page map, options field decode, register window decode, protection gate
// assumes cpu-side logic on clock_i owns page select and all requests
//
// Function
// (R01) The block has no off-chip pins; everything is reached from the cpu bus.
// (R02) Flash reads are answered across 4000 to FFFF as three 16 KB windows.
// (R03) The middle window 8000 to BFFF maps to the page named by the page select value.
// (R04) The cpu side owns and drives the page select value; this block only decodes it.
// (R05) Page values 30 to 3F each pick one 16 KB page, four per block, lowest values block 3.
// (R06) Page values 3F and 3E show a fixed window's page a second time in the middle window.
// (R07) A protecting open protection bit guards its whole block against program and erase.
// (R08) Each block has a lower area from page start and a higher area from page end.
// (R09) Software keeps its boot loader in the higher area of block 0, over the vectors.
// (R10) A 16-byte protection and options field sits inside block 0.
// (R11) Backdoor key bytes start at FF00 and the security byte is at FF0F.
// (R12) Protection bytes at FF0A to FF0D belong to blocks 3, 2, 1 and 0 in that order.
// (R13) Control and status registers decode in base plus 100 to base plus 10F.
// (R14) Both areas size in steps from 512 bytes to 4 KB.
// (R15) Offsets 104 to 10B are banked per block, chosen by the bank select bits.
// (R16) Program or erase into a protected block or area is blocked and flagged.
`timescale 1ns/10ps
`default_nettype none
module fpm_page_map
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic rd_i,
   input wire logic [15:0] rd_addr_i,
   input wire logic [7:0] page_select_value_i,
   input wire logic [1:0] bank_select_bits_i,
   input wire logic [31:0] block_protection_register_i,
   input wire logic pe_req_i,
   input wire logic [15:0] pe_addr_i,
   output fpm_pkg::fpm_map_s rd_map_o,
   output logic reg_hit_o,
   output logic reg_banked_o,
   output logic [3:0] reg_offset_o,
   output logic [1:0] reg_bank_o,
   output logic key_hit_o,
   output logic prot_byte_hit_o,
   output logic [1:0] prot_byte_block_o,
   output logic sec_byte_hit_o,
   output logic pe_grant_o,
   output logic pe_violation_o
);
   import fpm_pkg::*;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   // one map for reads and program/erase so both agree on aliasing
   function automatic fpm_map_s map_addr(input logic [15:0] a, input logic [7:0] pg);
      logic [7:0] p;
      map_addr = '0;
      p = pg;
      if (a >= FLASH_FIRST && a <= FIXED_LO_LAST)
         p = PAGE_FIXED_LO; // R02
      else if (a >= FIXED_HI_FIRST)
         p = PAGE_FIXED_HI; // R02
      // middle window takes the page value as is, 3E/3F alias a fixed page
      map_addr.hit = (a >= FLASH_FIRST) && (p >= PAGE_FIRST) && (p <= PAGE_LAST); // R03 R06
      // a miss leaves block and address at zero, no stale page bits
      if (map_addr.hit)
      begin
         map_addr.block = TOP_BLOCK - p[3:2]; // R05
         map_addr.addr = {p[1:0], a[13:0]}; // R05
      end
   endfunction

   function automatic logic [1:0] prot_of_block_sel(input logic [1:0] b);
      prot_of_block_sel = b;
   endfunction

   fpm_state_s state;
   fpm_state_s next_state;
   fpm_map_s rd_m;
   fpm_map_s pe_m;
   logic [7:0] pe_prot;
   logic pe_protected;
   logic [15:0] reg_rel;

   // ----------------------------------------
   // protection check for program/erase
   // ----------------------------------------
   fpm_area_check u_check
   (
      .addr_i(pe_m.addr),
      .prot_i(pe_prot),
      .protected_o(pe_protected)
   );

   always_comb
   begin
      rd_m = map_addr(rd_addr_i, page_select_value_i); // R04
      pe_m = map_addr(pe_addr_i, page_select_value_i);
      pe_prot = block_protection_register_i[{prot_of_block_sel(pe_m.block), 3'b000} +: 8]; // R07
      reg_rel = rd_addr_i - REG_BASE;
      next_state = state;
      next_state.rd = rd_i ? rd_m : '0; // R02
      next_state.reg_hit = rd_i && reg_rel >= REG_FIRST && reg_rel <= REG_LAST; // R13
      next_state.reg_offset = reg_rel[3:0];
      next_state.reg_banked = next_state.reg_hit && reg_rel[3:0] >= BANKED_FIRST
         && reg_rel[3:0] <= BANKED_LAST; // R15
      next_state.reg_bank = next_state.reg_banked ? bank_select_bits_i : RST_BLOCK; // R15
      // options field lives only in block 0, the top fixed page
      next_state.key_hit = rd_i && rd_m.hit && rd_m.block == RST_BLOCK
         && rd_m.addr >= KEY_FIRST && rd_m.addr <= KEY_LAST; // R10 R11
      next_state.prot_byte_hit = rd_i && rd_m.hit && rd_m.block == RST_BLOCK
         && rd_m.addr >= PROT_BYTE_FIRST && rd_m.addr <= PROT_BYTE_LAST; // R12
      next_state.prot_byte_block = TOP_BLOCK - rd_m.addr[1:0] + 2'h2; // R12
      next_state.sec_byte_hit = rd_i && rd_m.hit && rd_m.block == RST_BLOCK
         && rd_m.addr == SEC_BYTE; // R11
      // unmapped program/erase is refused as well, never silently granted
      next_state.pe_grant = pe_req_i && pe_m.hit && !pe_protected; // R16
      next_state.pe_violation = pe_req_i && (!pe_m.hit || pe_protected); // R16
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         state <= '0;
      else
         state <= next_state;
   end

   // ----------------------------------------
   // outputs, all registered, no pins
   // ----------------------------------------
   assign rd_map_o = state.rd; // R01
   assign reg_hit_o = state.reg_hit;
   assign reg_banked_o = state.reg_banked;
   assign reg_offset_o = state.reg_offset;
   assign reg_bank_o = state.reg_bank;
   assign key_hit_o = state.key_hit;
   assign prot_byte_hit_o = state.prot_byte_hit;
   assign prot_byte_block_o = state.prot_byte_block;
   assign sec_byte_hit_o = state.sec_byte_hit;
   assign pe_grant_o = state.pe_grant;
   assign pe_violation_o = state.pe_violation;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_window_hit;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i >= FLASH_FIRST && (rd_addr_i < MID_FIRST || rd_addr_i >= FIXED_HI_FIRST)
         |=> rd_map_o.hit && rd_map_o.block == RST_BLOCK;
   endproperty
   a_window_hit: assert property (p_window_hit) else $error("fixed window miss"); // R02

   property p_below_flash;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i < FLASH_FIRST |=> !rd_map_o.hit;
   endproperty
   a_below_flash: assert property (p_below_flash) else $error("hit below flash"); // R02

   property p_mid_page;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i >= MID_FIRST && rd_addr_i <= MID_LAST && page_select_value_i >= PAGE_FIRST
         && page_select_value_i <= PAGE_LAST
         |=> rd_map_o.hit && rd_map_o.addr[15:14] == $past(page_select_value_i[1:0]);
   endproperty
   a_mid_page: assert property (p_mid_page) else $error("middle page wrong"); // R03

   property p_block_order;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i >= MID_FIRST && rd_addr_i <= MID_LAST && page_select_value_i == PAGE_FIRST
         |=> rd_map_o.block == TOP_BLOCK;
   endproperty
   a_block_order: assert property (p_block_order) else $error("page 30 not block 3"); // R05

   property p_alias;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i >= MID_FIRST && rd_addr_i <= MID_LAST
         && page_select_value_i == PAGE_FIXED_HI
         |=> rd_map_o.block == RST_BLOCK && rd_map_o.addr[15:14] == 2'h3;
   endproperty
   a_alias: assert property (p_alias) else $error("3F alias wrong"); // R06

   property p_sec_byte;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i == SEC_BYTE |=> sec_byte_hit_o && !key_hit_o && !prot_byte_hit_o;
   endproperty
   a_sec_byte: assert property (p_sec_byte) else $error("security byte miss"); // R11

   property p_prot_byte;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i == PROT_BYTE_FIRST |=> prot_byte_hit_o && prot_byte_block_o == TOP_BLOCK;
   endproperty
   a_prot_byte: assert property (p_prot_byte) else $error("prot byte order"); // R12

   property p_reg_window;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i == REG_BASE + REG_LAST |=> reg_hit_o && reg_offset_o == 4'hF && !reg_banked_o;
   endproperty
   a_reg_window: assert property (p_reg_window) else $error("register window"); // R13

   property p_bank;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i == REG_BASE + REG_FIRST + 16'h0004
         |=> reg_banked_o && reg_bank_o == $past(bank_select_bits_i);
   endproperty
   a_bank: assert property (p_bank) else $error("bank select"); // R15

   property p_pe_exclusive;
      @(posedge clock_i) disable iff (rst_i)
      pe_req_i |=> pe_grant_o ^ pe_violation_o;
   endproperty
   a_pe_exclusive: assert property (p_pe_exclusive) else $error("grant and violation"); // R16

   property p_whole_block;
      @(posedge clock_i) disable iff (rst_i)
      pe_req_i && pe_m.hit && pe_prot[PROT_OPEN_BIT] == OPEN_PROTECTING |=> pe_violation_o;
   endproperty
   a_whole_block: assert property (p_whole_block) else $error("block not guarded"); // R07

   property p_no_req;
      @(posedge clock_i) disable iff (rst_i)
      !pe_req_i |=> !pe_grant_o && !pe_violation_o;
   endproperty
   a_no_req: assert property (p_no_req) else $error("spurious pe answer"); // R16

   property p_key_byte;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i == KEY_FIRST |=> key_hit_o && !sec_byte_hit_o && !prot_byte_hit_o;
   endproperty
   a_key_byte: assert property (p_key_byte) else $error("key byte miss"); // R11

   property p_miss_zero;
      @(posedge clock_i) disable iff (rst_i)
      rd_i && rd_addr_i < FLASH_FIRST |=> rd_map_o == '0;
   endproperty
   a_miss_zero: assert property (p_miss_zero) else $error("miss not cleared"); // R02

endmodule
`default_nettype wire

// *** fpm_cpu_model.sv ***
// cpu-side model holding the page select and bank select values
// assumes the bench loads both through one write strobe on clock_i
`timescale 1ns/10ps
`default_nettype none
module fpm_cpu_model
#(
   parameter logic [7:0] PAGE_RST = 8'h00
)
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic page_we_i,
   input wire logic [7:0] page_d_i,
   input wire logic [1:0] bank_d_i,
   output logic [7:0] page_select_value_o,
   output logic [1:0] bank_select_bits_o
);
   // page select lives here, never in the flash block
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         page_select_value_o <= PAGE_RST;
         bank_select_bits_o <= 2'h0;
      end
      else if (page_we_i)
      begin
         page_select_value_o <= page_d_i;
         bank_select_bits_o <= bank_d_i;
      end
   end
endmodule
`default_nettype wire

// *** fpm_page_map_tb_top.sv ***
// self-checking bench for the flash page map and protection gate
// assumes fpm_cpu_model drives the page select, reset value 00
`timescale 1ns/10ps
`default_nettype none
module fpm_page_map_tb_top;
   import fpm_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic pe_req = 1'b0;
   logic pg_we = 1'b0;
   logic [15:0] rd_addr = 16'h0000;
   logic [15:0] pe_addr = 16'h0000;
   logic [7:0] pg_d = 8'h00;
   logic [1:0] bk_d = 2'h0;
   logic [31:0] prot = 32'hFFFFFFFF;
   logic [7:0] cur_pg = 8'h00;
   logic [1:0] cur_bk = 2'h0;
   logic [7:0] pg;
   logic [1:0] bk;
   fpm_map_s rd_map;
   logic reg_hit, reg_banked, key_hit, pb_hit, sec_hit, grant, viol;
   logic [3:0] reg_off;
   logic [1:0] reg_bank, pb_blk;
   int err_count = 0;
   int n_checks = 0;
   int cycles = 0;
   always #10 clock = ~clock;
   fpm_cpu_model cpu_u (.clock_i(clock), .rst_i(rst), .page_we_i(pg_we), .page_d_i(pg_d),
      .bank_d_i(bk_d), .page_select_value_o(pg), .bank_select_bits_o(bk));
   fpm_page_map dut_u (.clock_i(clock), .rst_i(rst), .rd_i(rd), .rd_addr_i(rd_addr),
      .page_select_value_i(pg), .bank_select_bits_i(bk), .block_protection_register_i(prot),
      .pe_req_i(pe_req), .pe_addr_i(pe_addr), .rd_map_o(rd_map), .reg_hit_o(reg_hit),
      .reg_banked_o(reg_banked), .reg_offset_o(reg_off), .reg_bank_o(reg_bank),
      .key_hit_o(key_hit), .prot_byte_hit_o(pb_hit), .prot_byte_block_o(pb_blk),
      .sec_byte_hit_o(sec_hit), .pe_grant_o(grant), .pe_violation_o(viol));
   // ----------------------------------------
   // expectations and compares
   // ----------------------------------------
   function automatic fpm_map_s emap(input logic [15:0] a, input logic [7:0] p);
      fpm_map_s m;
      logic [7:0] q;
      m = '0;
      q = (a[15:14] == 2'h1) ? PAGE_FIXED_LO : (a[15:14] == 2'h3) ? PAGE_FIXED_HI : p;
      if (a >= FLASH_FIRST && q >= PAGE_FIRST && q <= PAGE_LAST)
      begin
         m.hit = 1'b1;
         m.block = TOP_BLOCK - q[3:2];
         m.addr = {q[1:0], a[13:0]};
      end
      return m;
   endfunction
   // unmapped counts as blocked too
   function automatic logic eviol(input fpm_map_s m, input logic [7:0] b);
      logic [16:0] r;
      r = {1'b0, m.addr};
      return !m.hit || b[7] == OPEN_PROTECTING
         || (!b[2] && r >= LOWER_AREA_BASE && r < LOWER_AREA_BASE + (AREA_MIN_BYTES << b[1:0]))
         || (!b[5] && r >= BLOCK_END - (AREA_MIN_BYTES << b[4:3]));
   endfunction
   task automatic chk_b(input string n, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_v(input string n, input logic [3:0] e, input logic [3:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_map(input string n, input fpm_map_s e, input fpm_map_s g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task summarize;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------
   // bus drivers
   // ----------------------------------------
   task automatic set_page(input logic [7:0] p, input logic [1:0] k);
      @(posedge clock);
      pg_we <= 1'b1;
      pg_d <= p;
      bk_d <= k;
      @(posedge clock);
      pg_we <= 1'b0;
      cur_pg = p;
      cur_bk = k;
   endtask
   task automatic set_prot(input logic [7:0] b);
      @(posedge clock);
      prot <= {4{b}};
      @(posedge clock);
   endtask
   task automatic do_rd(input logic [15:0] a);
      fpm_map_s m;
      logic b0, pb, rh, bk2;
      m = emap(a, cur_pg);
      b0 = m.hit && m.block == 2'h0;
      pb = b0 && m.addr >= PROT_BYTE_FIRST && m.addr <= PROT_BYTE_LAST;
      rh = a >= REG_BASE + REG_FIRST && a <= REG_BASE + REG_LAST;
      bk2 = rh && a[3:0] >= BANKED_FIRST && a[3:0] <= BANKED_LAST;
      @(posedge clock);
      rd <= 1'b1;
      rd_addr <= a;
      @(posedge clock);
      #1;
      chk_map("rd_map", m, rd_map);
      chk_b("key_hit", b0 && m.addr >= KEY_FIRST && m.addr <= KEY_LAST, key_hit);
      chk_b("sec_hit", b0 && m.addr == SEC_BYTE, sec_hit);
      chk_b("pbyte_hit", pb, pb_hit);
      if (pb)
         chk_v("pbyte_blk", {2'h0, 2'h3 - (m.addr[1:0] - 2'h2)}, {2'h0, pb_blk});
      chk_b("reg_hit", rh, reg_hit);
      if (rh)
         chk_v("reg_off", a[3:0], reg_off);
      chk_b("reg_banked", bk2, reg_banked);
      chk_v("reg_bank", {2'h0, bk2 ? cur_bk : 2'h0}, {2'h0, reg_bank});
   endtask
   task automatic do_pe(input logic [15:0] a);
      logic v;
      fpm_map_s m;
      m = emap(a, cur_pg);
      v = eviol(m, prot[8 * m.block +: 8]);
      @(posedge clock);
      pe_req <= 1'b1;
      pe_addr <= a;
      @(posedge clock);
      pe_req <= 1'b0;
      #1;
      chk_b("pe_violation", v, viol);
      chk_b("pe_grant", !v, grant);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_decode;
      logic [15:0] fx [5] = '{16'h3FFF, 16'h4000, 16'h7FFF, 16'hC000, 16'hFFFF};
      for (int p = 8'h2F; p <= 8'h40; p++)
      begin
         set_page(p[7:0], 2'h0);
         do_rd(16'h8123);
         do_rd(16'hBFFF);
      end
      foreach (fx[i])
         do_rd(fx[i]);
      $display("t_decode done");
   endtask
   task automatic t_options;
      set_page(8'h3F, 2'h0);
      for (int i = 0; i < 16; i++)
      begin
         do_rd(16'hFF00 + i[15:0]);
         do_rd(16'hBF00 + i[15:0]);
      end
      set_page(8'h3B, 2'h0);
      do_rd(16'hBF0D);
      $display("t_options done");
   endtask
   task automatic t_regs;
      for (int k = 0; k < 4; k++)
      begin
         set_page(8'h30, k[1:0]);
         for (int a = 16'h00FF; a <= 16'h0110; a++)
            do_rd(a[15:0]);
      end
      $display("t_regs done");
   endtask
   // area edges: lower last protected then first free byte, higher first protected then last free one
   task automatic t_prot;
      logic [15:0] sz;
      for (int s = 0; s < 4; s++)
      begin
         sz = 16'h0200 << s;
         set_page(8'h3A, 2'h0);
         set_prot({4'hC, 1'b0, 1'b0, s[1:0]});
         do_pe(16'h8000 + sz - 16'h0001);
         do_pe(16'h8000 + sz);
         set_page(8'h3B, 2'h0);
         set_prot({3'h4, s[1:0], 3'h4});
         do_pe(16'hC000 - sz);
         do_pe(16'hC000 - sz - 16'h0001);
         do_pe(16'hFFFE);
      end
      set_prot(8'h24);
      do_pe(16'h9000);
      set_prot(8'hA4);
      do_pe(16'h9000);
      do_pe(16'h2000);
      $display("t_prot done");
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         summarize();
      end
   end
   initial
   begin
      repeat (6) @(posedge clock);
      chk_b("pe_grant", 1'b0, grant);
      rst <= 1'b0;
      t_decode();
      t_options();
      t_regs();
      t_prot();
      summarize();
   end
endmodule
`default_nettype wire
